// File: pkg/fss_pkg.sv
// Constants, carrier types and bit layout of the flash sequencer status block
package fss_pkg;

    localparam logic [7:0] OFF_RAM_EN = 8'h00;
    localparam logic [7:0] OFF_STAT_MAIN = 8'h04;
    localparam logic [7:0] OFF_STAT_AUX = 8'h08;
    localparam logic [7:0] OFF_ECC_CTRL = 8'h0c;
    localparam logic [7:0] OFF_ACC_STAT = 8'h10;
    localparam logic [7:0] OFF_SOFT_RST = 8'h14;

    localparam logic [7:0] KEY_RAM_EN = 8'hc4;
    localparam logic [7:0] KEY_SOFT_RST = 8'hcc;
    localparam logic [3:0] STRB_HALF = 4'h3;
    localparam logic [7:0] ACC_CLEAR_OK = 8'h10;

    localparam int ST_READY = 7;
    localparam int ST_ILLEGAL = 6;
    localparam int ST_ERS_ERR = 5;
    localparam int ST_PRG_ERR = 4;
    localparam int ST_SUS_RDY = 3;
    localparam int ST_ERS_SPD = 1;
    localparam int ST_PRG_SPD = 0;
    localparam int AUX_FAULT = 7;
    localparam int AUX_LOCK = 4;
    localparam int AUX_DBL = 1;
    localparam int AUX_SGL = 0;
    localparam int ECC_DBL_EN = 1;
    localparam int ECC_SGL_EN = 0;
    localparam int ACC_LOCK = 4;

    localparam logic [7:0] RST_STAT_MAIN = 8'h80;
    localparam logic [7:0] RST_STAT_AUX = 8'h00;
    localparam logic [1:0] RST_ECC_CTRL = 2'h2;
    localparam logic RST_RAM_EN = 1'b0;
    localparam logic [15:0] FLAG_LIVE = 16'h93fb;

    // Events from the sequencer core, each a one-cycle pulse unless noted
    typedef struct packed {
        logic busy;          // Level: P/E, suspend, lock read or blank check
        logic illegal_cmd;
        logic entry_illegal;
        logic erase_fail;    // Failure or locked-block erase
        logic program_fail;  // Failure or locked-area program
        logic status_clear;  // Status-clear command finished
        logic suspend_point;
        logic suspend_taken;
        logic erase_susp;
        logic program_susp;
        logic resume_taken;
        logic cpu_fault;
        logic lock_read_done;
        logic lock_read_val; // Level, valid with lock_read_done
        logic ram_dbl_err;
        logic ram_sgl_err;
    } fss_evt_t;

endpackage : fss_pkg

// File: hdl/fss_status_ctrl.sv
// Status, ECC lock control and firmware-RAM gate of the flash sequencer
//
// Implementation choices: the placing of the registers and register access over APB.
module fss_status_ctrl (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire fss_pkg::fss_evt_t evt_i,
    input wire logic [7:0] access_err_i,
    input wire logic host_ram_req_i,
    output logic host_ram_grant_o,
    output logic ram_access_enable_o,
    output logic command_lock_o,
    output logic sequencer_soft_reset_o
);

    logic ram_en;
    logic soft_rst;
    logic [1:0] ecc_ctrl;
    logic cmd_lock;
    logic [15:0] flags;
    logic [31:0] rdata;
    logic slverr;

    // APB decode; answer comes in the first access cycle
    wire setup = psel_i & ~penable_i;
    wire wr_acc = psel_i & penable_i & pwrite_i;
    wire half_wr = pstrb_i == fss_pkg::STRB_HALF;
    wire [7:0] wkey = pwdata_i[15:8];
    wire hit_ram = paddr_i == fss_pkg::OFF_RAM_EN;
    wire hit_main = paddr_i == fss_pkg::OFF_STAT_MAIN;
    wire hit_aux = paddr_i == fss_pkg::OFF_STAT_AUX;
    wire hit_ecc = paddr_i == fss_pkg::OFF_ECC_CTRL;
    wire hit_acc = paddr_i == fss_pkg::OFF_ACC_STAT;
    wire hit_srst = paddr_i == fss_pkg::OFF_SOFT_RST;
    wire mapped = hit_ram | hit_main | hit_aux | hit_ecc | hit_acc | hit_srst;

    // Key byte is compared only, never stored
    wire wr_ram_en = wr_acc & hit_ram & half_wr
        & (wkey == fss_pkg::KEY_RAM_EN);
    wire wr_srst = wr_acc & hit_srst & half_wr
        & (wkey == fss_pkg::KEY_SOFT_RST);
    // Byte lane 0 holds both enables, so any write touching it counts
    wire wr_ecc = wr_acc & hit_ecc & pstrb_i[0];

    // Status registers held at initial values while soft reset is set
    wire stat_init = sys_rst_i | soft_rst;

    // ECC monitors update regardless of the enables
    wire ecc_lock_req = (evt_i.ram_dbl_err & ecc_ctrl[fss_pkg::ECC_DBL_EN])
        | (evt_i.ram_sgl_err & ecc_ctrl[fss_pkg::ECC_SGL_EN]);

    // Bit 4 of the access view is the lock flag itself, not an error
    wire [7:0] acc_err_bits = access_err_i
        & ~(8'h01 << fss_pkg::ACC_LOCK);
    wire acc_err_any = |acc_err_bits;
    wire illegal_set = evt_i.illegal_cmd | evt_i.entry_illegal
        | acc_err_any;
    wire lock_set = illegal_set | evt_i.erase_fail | evt_i.program_fail
        | ecc_lock_req;

    // Access status as software sees it, lock flag merged in
    wire [7:0] acc_stat = (access_err_i
        & ~(8'h01 << fss_pkg::ACC_LOCK))
        | ({7'h00, cmd_lock} << fss_pkg::ACC_LOCK);
    wire clear_ok = evt_i.status_clear
        & (acc_stat == fss_pkg::ACC_CLEAR_OK);

    // Set and clear per flag: {aux, main}
    logic [15:0] f_set;
    logic [15:0] f_clr;
    always_comb begin
        f_set = 16'h0000;
        f_clr = 16'h0000;
        f_set[fss_pkg::ST_READY] = ~evt_i.busy;
        f_clr[fss_pkg::ST_READY] = evt_i.busy;
        f_set[fss_pkg::ST_ILLEGAL] = illegal_set;
        f_clr[fss_pkg::ST_ILLEGAL] = clear_ok;
        f_set[fss_pkg::ST_ERS_ERR] = evt_i.erase_fail;
        f_clr[fss_pkg::ST_ERS_ERR] = evt_i.status_clear;
        f_set[fss_pkg::ST_PRG_ERR] = evt_i.program_fail;
        f_clr[fss_pkg::ST_PRG_ERR] = evt_i.status_clear;
        f_set[fss_pkg::ST_SUS_RDY] = evt_i.suspend_point;
        f_clr[fss_pkg::ST_SUS_RDY] = evt_i.suspend_taken
            | (lock_set & evt_i.busy);
        f_set[fss_pkg::ST_ERS_SPD] = evt_i.erase_susp;
        f_clr[fss_pkg::ST_ERS_SPD] = evt_i.resume_taken;
        f_set[fss_pkg::ST_PRG_SPD] = evt_i.program_susp;
        f_clr[fss_pkg::ST_PRG_SPD] = evt_i.resume_taken;
        f_set[8 + fss_pkg::AUX_FAULT] = evt_i.cpu_fault;
        f_set[8 + fss_pkg::AUX_LOCK] = evt_i.lock_read_done
            & evt_i.lock_read_val;
        f_clr[8 + fss_pkg::AUX_LOCK] = evt_i.lock_read_done
            & ~evt_i.lock_read_val;
        f_set[8 + fss_pkg::AUX_DBL] = evt_i.ram_dbl_err;
        f_set[8 + fss_pkg::AUX_SGL] = evt_i.ram_sgl_err;
    end

    localparam logic [15:0] FLAG_INIT =
        {fss_pkg::RST_STAT_AUX, fss_pkg::RST_STAT_MAIN};

    // Set wins over clear so a same-cycle event is never lost
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (fss_pkg::FLAG_LIVE[gi]) begin : g_live
                always_ff @(posedge sys_clk_i) begin
                    if (stat_init) begin
                        flags[gi] <= FLAG_INIT[gi];
                    end else begin
                        flags[gi] <= (flags[gi] & ~f_clr[gi]) | f_set[gi];
                    end
                end
            end else begin : g_rsvd
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    // Command lock; cleared with the illegal flag by a valid status clear
    always_ff @(posedge sys_clk_i) begin
        if (stat_init) begin
            cmd_lock <= 1'b0;
        end else begin
            cmd_lock <= (cmd_lock & ~clear_ok) | lock_set;
        end
    end

    // RAM enable is not cleared by the soft reset, only by the pin
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ram_en <= fss_pkg::RST_RAM_EN;
            soft_rst <= 1'b0;
            ecc_ctrl <= fss_pkg::RST_ECC_CTRL;
        end else begin
            if (wr_ram_en) begin
                ram_en <= pwdata_i[0];
            end
            if (wr_srst) begin
                soft_rst <= pwdata_i[0];
            end
            if (wr_ecc) begin
                ecc_ctrl <= pwdata_i[1:0];
            end
        end
    end

    // Read mux; status writes fall through with no effect
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_ram) begin
            rdata[0] = ram_en;
        end else if (hit_main) begin
            rdata[7:0] = flags[7:0];
        end else if (hit_aux) begin
            rdata[7:0] = flags[15:8];
        end else if (hit_ecc) begin
            rdata[1:0] = ecc_ctrl;
        end else if (hit_acc) begin
            rdata[7:0] = acc_stat;
        end else if (hit_srst) begin
            rdata[0] = soft_rst;
        end
    end

    // Read-only status registers answer writes without error
    always_comb begin
        slverr = ~mapped;
    end

    // Read data captured at setup so it comes from a flip-flop
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rdata;
            pslverr_o <= slverr;
        end
    end

    assign pready_o = 1'b1;
    assign ram_access_enable_o = ram_en;
    assign host_ram_grant_o = host_ram_req_i & ram_en;
    assign command_lock_o = cmd_lock;
    assign sequencer_soft_reset_o = soft_rst;

endmodule : fss_status_ctrl

// File: verif/fss_status_ctrl_chk.sv
// Port-level assertions for the flash sequencer status block
module fss_status_ctrl_chk (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire fss_pkg::fss_evt_t evt_i,
    input wire logic [7:0] access_err_i,
    input wire logic host_ram_req_i,
    input wire logic host_ram_grant_o,
    input wire logic ram_access_enable_o,
    input wire logic command_lock_o,
    input wire logic sequencer_soft_reset_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic setup = psel_i && !penable_i && !pwrite_i;
    wire logic fire = psel_i && penable_i && pwrite_i && pready_o;
    wire logic keyed = fire && pstrb_i == fss_pkg::STRB_HALF;
    wire logic [7:0] key = pwdata_i[15:8];
    wire logic mapped = paddr_i[1:0] == 2'h0 && paddr_i <= 8'h14;
    wire logic acc_err = (access_err_i & 8'hef) != 8'h00;
    wire logic srst = sequencer_soft_reset_o;

    a_grant_gate: assert property (
        host_ram_grant_o == (host_ram_req_i && ram_access_enable_o))
        else $error("grant does not follow enable");
    a_ram_en_key: assert property ($changed(ram_access_enable_o) |->
        $past(sys_rst_i) || $past(keyed && paddr_i == 8'h00 && key == 8'hc4))
        else $error("ram enable changed without key");
    a_soft_rst_key: assert property ($changed(srst) |->
        $past(sys_rst_i) || $past(keyed && paddr_i == 8'h14 && key == 8'hcc))
        else $error("soft reset changed without key");
    a_pe_err_lock: assert property (
        (evt_i.erase_fail || evt_i.program_fail) && !srst |=> command_lock_o)
        else $error("program or erase error did not lock");
    a_illegal_lock: assert property (!srst && (evt_i.illegal_cmd ||
        evt_i.entry_illegal || acc_err) |=> command_lock_o)
        else $error("illegal condition did not lock");
    a_lock_release: assert property ($fell(command_lock_o) |->
        $past(sys_rst_i || srst || evt_i.status_clear && !acc_err))
        else $error("lock released without clear");
    a_soft_rst_hold: assert property (srst |=> !command_lock_o)
        else $error("lock held during soft reset");
    a_rsvd_zero: assert property (setup && mapped |=>
        prdata_o[31:8] == 24'h0) else $error("upper read bits not zero");
    a_key_rd_zero: assert property (setup && paddr_i == 8'h00 |=>
        prdata_o == {31'h0, ram_access_enable_o})
        else $error("ram enable readback wrong");
endmodule : fss_status_ctrl_chk

bind fss_status_ctrl fss_status_ctrl_chk u_chk (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .evt_i(evt_i), .access_err_i(access_err_i),
    .host_ram_req_i(host_ram_req_i), .host_ram_grant_o(host_ram_grant_o),
    .ram_access_enable_o(ram_access_enable_o),
    .command_lock_o(command_lock_o),
    .sequencer_soft_reset_o(sequencer_soft_reset_o));

// File: verif/testbench.sv
// Self-checking bench for the flash sequencer status block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, req = 0, err;
    logic [7:0] addr = 0, aerr = 0;
    logic [31:0] wd = 0, rd;
    logic [3:0] strb = 0;
    fss_pkg::fss_evt_t evt = '0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, grant, ramen, lock, srst;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    // Each entry: event, access errors, expected main, aux, lock
    logic [47:0] tab [17] = '{48'h1000_00a0_0001, 48'h0800_00b0_0001,
        48'h4000_00f0_0001, 48'h0400_0080_0000, 48'h0200_0088_0000,
        48'h0100_0080_0000, 48'h0080_0082_0000, 48'h0040_0083_0000,
        48'h0020_0080_0000, 48'h000c_0080_1000, 48'h0008_0080_0000,
        48'h0010_0080_8000, 48'h0001_0080_8100, 48'h0002_0080_8301,
        48'h2000_00c0_8301, 48'h0400_01c0_8301, 48'h0400_0080_8300};

    initial forever #50 clk = ~clk;

    fss_status_ctrl dut (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd),
        .pstrb_i(strb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .evt_i(evt), .access_err_i(aerr),
        .host_ram_req_i(req), .host_ram_grant_o(grant),
        .ram_access_enable_o(ramen), .command_lock_o(lock),
        .sequencer_soft_reset_o(srst));

    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        psel <= 1;
        pwr <= w;
        addr <= a;
        wd <= d;
        strb <= s;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask : apb

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(0, a, 32'h0, 4'h0);
        chk(nm, rd, exp);
    endtask : rd_chk

    task automatic finish_test;
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] d;
        logic [3:0] s;
        logic en, e1;
        logic [1:0] ecc;
        en = 0;
        ecc = 2'h2;
        void'($urandom(32));
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd_chk("main", 8'h04, {24'h0, fss_pkg::RST_STAT_MAIN});
        rd_chk("eccctl", 8'h0c, 32'h2);
        foreach (tab[i]) begin
            aerr <= tab[i][31:24];
            evt <= fss_pkg::fss_evt_t'(tab[i][47:32]);
            @(posedge clk);
            evt <= '0;
            @(posedge clk);
            rd_chk("main", 8'h04, tab[i][23:16]);
            rd_chk("aux", 8'h08, tab[i][15:8]);
            chk("lock", lock, tab[i][0]);
        end
        evt.busy <= 1'b1;
        @(posedge clk);
        rd_chk("busy", 8'h04, 32'h0);
        evt.busy <= 1'b0;
        @(posedge clk);
        apb(1, 8'h04, 32'hff, 4'hf);
        rd_chk("rowrite", 8'h04, 32'h80);
        rd_chk("unmapped", 8'h20, 32'h0);
        chk("slverr", err, 1'b1);
        // Random keyed writes; the right key must pair with a half strobe
        repeat (24) begin
            d = $urandom;
            s = $urandom;
            e1 = $urandom;
            req <= $urandom;
            if (e1) d[15:8] = 8'hc4;
            apb(1, 8'h00, d, s);
            if (d[15:8] == 8'hc4 && s == 4'h3) en = d[0];
            rd_chk("ramen", 8'h00, {31'h0, en});
            chk("ramen_o", ramen, en);
            chk("grant", grant, req & en);
            apb(1, 8'h0c, d, s);
            if (s[0]) ecc = d[1:0];
            rd_chk("eccctl", 8'h0c, {30'h0, ecc});
        end
        apb(1, 8'h14, 32'h0000cd01, 4'h3);
        rd_chk("aux", 8'h08, 32'h83);
        apb(1, 8'h14, 32'h0000cc01, 4'h3);
        chk("srst_o", srst, 1'b1);
        rd_chk("aux", 8'h08, 32'h0);
        rd_chk("srstrd", 8'h14, 32'h1);
        apb(1, 8'h14, 32'h0000cc00, 4'h3);
        rd_chk("main", 8'h04, 32'h80);
        chk("srst_o", srst, 1'b0);
        // Second reset in mid-run
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd_chk("rstram", 8'h00, 32'h0);
        rd_chk("rstecc", 8'h0c, 32'h2);
        chk("rstlock", lock, 1'b0);
        finish_test();
    end
endmodule : testbench
